/* File: core/gdfm_regs.svh */
// Timing constants and fault-code encodings of the gate driver fault monitor.
`ifndef GDFM_REGS_SVH
`define GDFM_REGS_SVH
// Clock period in picoseconds (40 MHz).
`define GDFM_CLK_PS          25000
// Overcurrent filter time in microseconds.
`define GDFM_OC_FILTER_US    10
// Short-circuit blanking after a PWM rising edge, microseconds.
`define GDFM_SC_BLANK_US     5
// Short-circuit debounce in microseconds (figure not printed).
`define GDFM_SC_DEB_US       1
// Run request low time before standby, microseconds.
`define GDFM_RUN_DEB_US      500
// Reset pin debounce in microseconds (figure not printed).
`define GDFM_RST_DEB_US      2
// Cycles derived from the times above; only the overcurrent filter rounds down.
`define GDFM_OC_CYC   ((`GDFM_OC_FILTER_US * 1000000) / `GDFM_CLK_PS)
`define GDFM_BLANK_CYC ((`GDFM_SC_BLANK_US * 1000000 + `GDFM_CLK_PS - 1) \
   / `GDFM_CLK_PS)
`define GDFM_SCDEB_CYC ((`GDFM_SC_DEB_US * 1000000 + `GDFM_CLK_PS - 1) \
   / `GDFM_CLK_PS)
`define GDFM_RUNDEB_CYC ((`GDFM_RUN_DEB_US * 1000000 + `GDFM_CLK_PS - 1) \
   / `GDFM_CLK_PS)
`define GDFM_RSTDEB_CYC ((`GDFM_RST_DEB_US * 1000000 + `GDFM_CLK_PS - 1) \
   / `GDFM_CLK_PS)
// Error flag codes, high flag in bit 1, low flag in bit 0.
`define GDFM_CODE_NONE   2'h0
`define GDFM_CODE_GATEUV 2'h1
`define GDFM_CODE_TEMP   2'h2
`define GDFM_CODE_BOTH   2'h3
`endif

/* File: core/gdfm_pkg.sv */
// Types shared by the gate driver fault monitor modules.
package gdfm_pkg;
   // Operating states, one-hot.
   typedef enum logic [2:0] {
      ST_SLEEP   = 3'b001,
      ST_STANDBY = 3'b010,
      ST_RUN     = 3'b100
   } state_t;
endpackage

/* File: core/gdfm_leg_if.sv */
// Signals between the fault monitor and one half-bridge leg supervisor.
`timescale 1ns/1ps
interface gdfm_leg_if;
   logic pwm_high;      // Requested high-side state.
   logic pwm_low;       // Requested low-side state.
   logic trip_high;     // High-side drain-source comparator.
   logic trip_low;      // Low-side drain-source comparator.
   logic active;        // Run state and drivers allowed.
   logic clear;         // Fault clear while run request is low.
   logic gate_high;     // Registered high-side gate.
   logic gate_low;      // Registered low-side gate.
   logic short_fault;   // Latched short-circuit fault of this leg.
   modport top (output pwm_high, pwm_low, trip_high, trip_low, active,
      clear, input gate_high, gate_low, short_fault);
   modport leg (input pwm_high, pwm_low, trip_high, trip_low, active,
      clear, output gate_high, gate_low, short_fault);
endinterface

/* File: core/gdfm_leg.sv */
// Supervisor of one half-bridge: blanking, short debounce and interlock.
`timescale 1ns/1ps
`include "gdfm_regs.svh"
module gdfm_leg #(
   parameter int BLANK_CYC = `GDFM_BLANK_CYC,  // Blanking in cycles.
   parameter int DEB_CYC   = `GDFM_SCDEB_CYC   // Debounce in cycles.
) (
   input wire logic CLOCK,  // System clock.
   input wire logic RST_N,  // Asynchronous reset, active low.
   gdfm_leg_if.leg  lg      // Leg signals.
);
   logic [7:0] blank_cnt;   // Blanking counter since the turn-on edge.
   logic [7:0] deb_cnt;     // Cycles the comparator has stayed tripped.
   logic       prev_high;   // Previous high-side request.
   logic       prev_low;    // Previous low-side request.
   logic       on_high;     // High side requested and conducting.
   logic       on_low;      // Low side requested and conducting.
   logic       trip;        // Comparator of the conducting FET.
   logic       rise;        // A turn-on edge in this cycle.
   logic       armed;       // Trip seen outside the blanking window.

   // Only the conducting FET's comparator counts; none outside run.
   assign on_high = lg.pwm_high & ~lg.pwm_low;
   assign on_low  = lg.pwm_low & ~lg.pwm_high;
   assign trip = lg.active & ((on_high & lg.trip_high) |
      (on_low & lg.trip_low));
   // The turn-on edge itself is blanked too, before the counter loads.
   assign rise  = (lg.pwm_high & ~prev_high) | (lg.pwm_low & ~prev_low);
   assign armed = trip & (blank_cnt == 8'h00) & ~rise;

   // ***********************************************************
   // Blanking after each turn-on edge.
   // ***********************************************************
   // A rising request restarts the window, so a switching transient
   // shorter than the window never counts as a short.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         prev_high <= 1'b0;
         prev_low  <= 1'b0;
         blank_cnt <= 8'h00;
      end else begin
         prev_high <= lg.pwm_high;
         prev_low  <= lg.pwm_low;
         if (rise) begin
            blank_cnt <= 8'(BLANK_CYC);
         end else if (blank_cnt != 8'h00) begin
            blank_cnt <= blank_cnt - 8'h01;
         end
      end
   end

   // ***********************************************************
   // Debounce and latch of the short-circuit fault.
   // ***********************************************************
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         deb_cnt        <= 8'h00;
         lg.short_fault <= 1'b0;
      end else begin
         if (armed) begin
            if (deb_cnt != 8'(DEB_CYC)) begin
               deb_cnt <= deb_cnt + 8'h01;
            end
         end else begin
            deb_cnt <= 8'h00;
         end
         // The set wins over a clear in the same cycle.
         if (armed && deb_cnt == 8'(DEB_CYC - 1)) begin
            lg.short_fault <= 1'b1;
         end else if (lg.clear) begin
            lg.short_fault <= 1'b0;
         end
      end
   end

   // ***********************************************************
   // Registered gate outputs with interlock.
   // ***********************************************************
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         lg.gate_high <= 1'b0;
         lg.gate_low  <= 1'b0;
      end else begin
         // A tripped leg is held off until the fault is cleared.
         lg.gate_high <= lg.active & ~lg.short_fault & on_high;
         lg.gate_low  <= lg.active & ~lg.short_fault & on_low;
      end
   end

   a_gate_interlock: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      !(lg.gate_high && lg.gate_low))
      else $error("Both gates of one leg are on.");
   a_fault_off: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      lg.short_fault |=> !lg.gate_high && !lg.gate_low)
      else $error("Tripped leg still drives a gate.");
   a_blank_hold: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      $rose(lg.pwm_high) && !lg.short_fault |=> !lg.short_fault [*2])
      else $error("Short fault set inside blanking.");
endmodule

/* File: core/gdfm_top.sv */
// Fault supervision and error reporting of a three-phase gate driver.
`timescale 1ns/1ps
`include "gdfm_regs.svh"
// How it works
// - Faults encoded on two active-high flags.
// - Gate undervoltage: low flag, drivers off.
// - Gate supply recovery clears and re-enables.
// - Warning temperature raises unlatched warning.
// - Switch-off temperature enters sleep.
// - Filtered overcurrent latches fault, drivers off.
// - Overcurrent cleared by run request cycle.
// - Short disables only its own half-bridge.
// - Short comparator blanked after turn-on edge.
// - Debounced short turns FET off, both flags.
// - Short indication held until run low.
// - Overcurrent sensing only while run high.
// - Run low: both flags only logic undervoltage.
// - External reset pin is debounced.
// - Standby only after long run-low time.
// - Standby and sleep: gates low, no sensing.
// - Interlock keeps half-bridge sides exclusive.
module gdfm_top #(
   parameter int LEGS      = 3,                  // Half-bridges.
   parameter int OC_CYC    = `GDFM_OC_CYC,       // Overcurrent filter.
   parameter int RUNDEB_CYC = `GDFM_RUNDEB_CYC,  // Run low debounce.
   parameter int RSTDEB_CYC = `GDFM_RSTDEB_CYC   // Reset pin debounce.
) (
   input  wire logic            CLOCK,            // 40 MHz clock.
   input  wire logic            RST_N,            // Power-on reset.
   input  wire logic            EXTERNAL_RESET_PIN_N, // Reset pin.
   input  wire logic            ENABLE,           // Wake-up enable.
   input  wire logic            RUN,              // Run request.
   input  wire logic [LEGS-1:0] PWM_HIGH,         // High-side requests.
   input  wire logic [LEGS-1:0] PWM_LOW,          // Low-side requests.
   input  wire logic [LEGS-1:0] TRIP_HIGH,        // High-side comparators.
   input  wire logic [LEGS-1:0] TRIP_LOW,         // Low-side comparators.
   input  wire logic            GATE_SUPPLY_RAIL_UV, // Gate supply low.
   input  wire logic            LOGIC_SUPPLY_UV,  // Logic supply low.
   input  wire logic            TEMP_WARN,        // Warning threshold.
   input  wire logic            TEMP_OFF,         // Switch-off threshold.
   input  wire logic            OVERCURRENT,      // Amplifier comparator.
   output logic [LEGS-1:0]      HIGH_SIDE_GATE,   // High-side gates.
   output logic [LEGS-1:0]      LOW_SIDE_GATE,    // Low-side gates.
   output logic                 FAULT_FLAG_LOW,   // Low error flag.
   output logic                 FAULT_FLAG_HIGH,  // High error flag.
   output logic                 SENSE_ENABLE,     // Amplifier enable.
   output logic                 SUPPLY_ENABLE,    // Power supplies on.
   output logic                 SYSTEM_RESET_N    // Debounced reset.
);
   gdfm_pkg::state_t state;        // Operating state.
   gdfm_pkg::state_t next_state;   // Next operating state.
   logic [15:0] run_low_cnt;       // Cycles run has stayed low.
   logic [15:0] oc_cnt;            // Cycles overcurrent has stayed high.
   logic [15:0] rst_cnt;           // Reset pin stable-low counter.
   logic        oc_fault;          // Latched overcurrent.
   logic        run_prev;          // Run request one cycle ago.
   logic        fault_clear;       // Clears latched faults.
   logic        drive_ok;          // Drivers allowed this cycle.
   logic [LEGS-1:0] short_vec;     // Latched short per leg.
   logic [LEGS-1:0] gate_high_vec; // Leg high gate outputs.
   logic [LEGS-1:0] gate_low_vec;  // Leg low gate outputs.
   logic [1:0]  next_code;         // Next error flag code.

   // Latched faults clear while the request is low, so the rising
   // edge that follows starts the drivers on a clean slate.
   assign fault_clear = ~RUN;
   // Gate undervoltage and latched overcurrent stop all drivers; the
   // gate supply check is level based, so recovery re-enables. A low
   // request also holds them off, so a cleared latch only restarts
   // the drivers once the request is high again.
   assign drive_ok = (state == gdfm_pkg::ST_RUN) & RUN
      & ~GATE_SUPPLY_RAIL_UV & ~oc_fault;

   // ***********************************************************
   // Half-bridge supervisors.
   // ***********************************************************
   for (genvar i = 0; i < LEGS; i++) begin : g_leg
      gdfm_leg_if lif ();
      assign lif.pwm_high  = PWM_HIGH[i];
      assign lif.pwm_low   = PWM_LOW[i];
      assign lif.trip_high = TRIP_HIGH[i];
      assign lif.trip_low  = TRIP_LOW[i];
      assign lif.active    = drive_ok;
      assign lif.clear     = fault_clear;
      assign gate_high_vec[i] = lif.gate_high;
      assign gate_low_vec[i]  = lif.gate_low;
      assign short_vec[i]     = lif.short_fault;
      gdfm_leg u_leg (
         .CLOCK (CLOCK),
         .RST_N (RST_N),
         .lg    (lif.leg)
      );
   end

   // ***********************************************************
   // Operating state.
   // ***********************************************************
   // Next state; a switch-off temperature overrides everything.
   always_comb begin
      next_state = state;
      case (state)
         gdfm_pkg::ST_SLEEP: begin
            if (ENABLE && !TEMP_OFF) begin
               next_state = gdfm_pkg::ST_STANDBY;
            end
         end
         gdfm_pkg::ST_STANDBY: begin
            if (TEMP_OFF || !ENABLE) begin
               next_state = gdfm_pkg::ST_SLEEP;
            end else if (RUN) begin
               next_state = gdfm_pkg::ST_RUN;
            end
         end
         gdfm_pkg::ST_RUN: begin
            if (TEMP_OFF) begin
               next_state = gdfm_pkg::ST_SLEEP;
            end else if (run_low_cnt >= 16'(RUNDEB_CYC)) begin
               next_state = gdfm_pkg::ST_STANDBY;
            end
         end
         default: begin
            next_state = gdfm_pkg::ST_SLEEP;
         end
      endcase
   end

   // State register.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state <= gdfm_pkg::ST_SLEEP;
      end else begin
         state <= next_state;
      end
   end

   // Run request low-time counter; any high restarts it.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         run_low_cnt <= 16'h0000;
         run_prev    <= 1'b0;
      end else begin
         run_prev <= RUN;
         if (RUN) begin
            run_low_cnt <= 16'h0000;
         end else if (run_low_cnt != 16'hFFFF) begin
            run_low_cnt <= run_low_cnt + 16'h0001;
         end
      end
   end

   // ***********************************************************
   // Overcurrent filter and latch.
   // ***********************************************************
   // Sensing runs only with the request high, so a stale comparator
   // level during standby cannot latch a fault.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         oc_cnt   <= 16'h0000;
         oc_fault <= 1'b0;
      end else begin
         if (OVERCURRENT && RUN && state == gdfm_pkg::ST_RUN) begin
            if (oc_cnt != 16'hFFFF) begin
               oc_cnt <= oc_cnt + 16'h0001;
            end
         end else begin
            oc_cnt <= 16'h0000;
         end
         // Longer than the filter time: set wins over clear.
         if (OVERCURRENT && RUN && oc_cnt >= 16'(OC_CYC)) begin
            oc_fault <= 1'b1;
         end else if (fault_clear) begin
            oc_fault <= 1'b0;
         end
      end
   end

   // ***********************************************************
   // Error flags, drivers and supply outputs.
   // ***********************************************************
   // Priority encoder for the two flags.
   always_comb begin
      next_code = `GDFM_CODE_NONE;
      if (RUN && (oc_fault || short_vec != '0)) begin
         next_code = `GDFM_CODE_BOTH;
      end else if (LOGIC_SUPPLY_UV) begin
         next_code = `GDFM_CODE_BOTH;
      end else if (RUN && GATE_SUPPLY_RAIL_UV) begin
         next_code = `GDFM_CODE_GATEUV;
      end else if (RUN && TEMP_WARN) begin
         next_code = `GDFM_CODE_TEMP;
      end
   end

   // Flag registers; reset loads both high at start, the logic undervoltage code.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         FAULT_FLAG_LOW  <= 1'b1;
         FAULT_FLAG_HIGH <= 1'b1;
      end else begin
         FAULT_FLAG_LOW  <= next_code[0];
         FAULT_FLAG_HIGH <= next_code[1];
      end
   end

   // Gates pass through one register so the leg outputs stay aligned.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         HIGH_SIDE_GATE <= '0;
         LOW_SIDE_GATE  <= '0;
         SENSE_ENABLE   <= 1'b0;
         SUPPLY_ENABLE  <= 1'b0;
      end else begin
         HIGH_SIDE_GATE <= drive_ok ? gate_high_vec : '0;
         LOW_SIDE_GATE  <= drive_ok ? gate_low_vec : '0;
         SENSE_ENABLE   <= RUN & (state == gdfm_pkg::ST_RUN);
         SUPPLY_ENABLE  <= (next_state != gdfm_pkg::ST_SLEEP);
      end
   end

   // ***********************************************************
   // External reset pin debounce.
   // ***********************************************************
   // A spike shorter than the debounce window never reaches the
   // system reset; release is immediate once the pin returns high.
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_cnt        <= 16'h0000;
         SYSTEM_RESET_N <= 1'b0;
      end else if (EXTERNAL_RESET_PIN_N) begin
         rst_cnt        <= 16'h0000;
         SYSTEM_RESET_N <= 1'b1;
      end else if (rst_cnt >= 16'(RSTDEB_CYC)) begin
         SYSTEM_RESET_N <= 1'b0;
      end else begin
         rst_cnt <= rst_cnt + 16'h0001;
      end
   end

   // ***********************************************************
   // Checks.
   // ***********************************************************
   // A drop of the request only starts the run debounce.
   sequence s_run_drop;
      RUN ##1 !RUN;
   endsequence
   // A pin that has just gone low is still inside its window.
   sequence s_pin_drop;
      EXTERNAL_RESET_PIN_N ##1 !EXTERNAL_RESET_PIN_N;
   endsequence
   a_standby_hold: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      s_run_drop ##0 (state == gdfm_pkg::ST_RUN && !TEMP_OFF)
      |=> state == gdfm_pkg::ST_RUN)
      else $error("Left run before the run debounce.");
   a_oc_latch: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      oc_fault && RUN |=> oc_fault)
      else $error("Overcurrent fault cleared with run high.");
   a_oc_clear: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      $fell(oc_fault) |-> !run_prev)
      else $error("Overcurrent latch dropped without a run low.");
   a_oc_filter: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      $rose(oc_fault) |-> $past(oc_cnt) >= 16'(OC_CYC))
      else $error("Overcurrent latched before the filter time.");
   a_oc_gates_off: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      oc_fault |=> HIGH_SIDE_GATE == '0 && LOW_SIDE_GATE == '0)
      else $error("Gates on with overcurrent latched.");
   a_idle_gates: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      state != gdfm_pkg::ST_RUN |=> HIGH_SIDE_GATE == '0
      && LOW_SIDE_GATE == '0)
      else $error("Gates on outside run.");
   a_logic_uv_code: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      LOGIC_SUPPLY_UV |=> FAULT_FLAG_LOW && FAULT_FLAG_HIGH)
      else $error("Logic undervoltage not shown on both flags.");
   a_run_low_quiet: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      !RUN && !LOGIC_SUPPLY_UV |=> !FAULT_FLAG_LOW && !FAULT_FLAG_HIGH)
      else $error("Flags raised with run low and logic supply good.");
   a_gate_uv_code: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      RUN && GATE_SUPPLY_RAIL_UV && !LOGIC_SUPPLY_UV && !oc_fault
      && short_vec == '0 |=> FAULT_FLAG_LOW && !FAULT_FLAG_HIGH)
      else $error("Gate undervoltage code wrong.");
   a_temp_code: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      RUN && TEMP_WARN && !GATE_SUPPLY_RAIL_UV && !LOGIC_SUPPLY_UV
      && !oc_fault && short_vec == '0
      |=> !FAULT_FLAG_LOW && FAULT_FLAG_HIGH)
      else $error("Temperature warning code wrong.");
   a_short_code: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      RUN && short_vec != '0 |=> FAULT_FLAG_LOW && FAULT_FLAG_HIGH)
      else $error("Short fault not shown on both flags.");
   a_temp_off: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      TEMP_OFF |=> state == gdfm_pkg::ST_SLEEP && !SUPPLY_ENABLE)
      else $error("Switch-off temperature did not sleep.");
   a_sense_gate: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      !RUN |=> !SENSE_ENABLE)
      else $error("Sense amplifier on with run low.");
   a_pin_spike: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      s_pin_drop |=> SYSTEM_RESET_N)
      else $error("Reset pin spike reached the system reset.");
endmodule

/* File: dv/gdfm_mcu_model.sv */
// Behavioural model of the motor control unit that drives run and PWM.
`timescale 1ns/1ps
module gdfm_mcu_model (
   input  wire logic       clock,     // System clock.
   input  wire logic       rst_n,     // Reset, active low.
   input  wire logic       run_req,   // Run wanted by the scenario.
   input  wire logic       auto_drop, // Drop run when both flags rise.
   input  wire logic [2:0] pwm_h_req, // Wanted high-side states.
   input  wire logic [2:0] pwm_l_req, // Wanted low-side states.
   input  wire logic       flag_low,  // Low error flag seen.
   input  wire logic       flag_high, // High error flag seen.
   output logic            run,       // Run request to the driver.
   output logic [2:0]      pwm_high,  // High-side requests.
   output logic [2:0]      pwm_low    // Low-side requests.
);
   logic dropped;   // Run was dropped after both flags rose.
   logic next_drop; // Drop decision for this cycle.
   // Both flags high in run means drop at once; firmware keeps run
   // down until its own request is withdrawn, so no retry storm.
   assign next_drop = dropped
      | (auto_drop & run & flag_low & flag_high);
   // Requests change only on the rising edge, as firmware writes would.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dropped <= 1'b0;
         run <= 1'b0;
         pwm_high <= 3'h0;
         pwm_low <= 3'h0;
      end else begin
         dropped <= next_drop & run_req;
         run <= run_req & ~next_drop;
         pwm_high <= pwm_h_req;
         pwm_low <= pwm_l_req;
      end
   end
endmodule

/* File: dv/gate_driver_fault_monitor_tb.sv */
// Self-checking testbench of the gate driver fault monitor.
`timescale 1ns/1ps
module gate_driver_fault_monitor_tb;
   logic clock, rst_n, ext_n, enable, gate_uv, logic_uv;
   logic temp_warn, temp_off, ovc, run_req, auto_drop, run;
   logic [2:0] pwm_h_req, pwm_l_req, pwm_h, pwm_l, trip_h, trip_l;
   logic [2:0] gate_h, gate_l;
   logic fl_lo, fl_hi, sense_en, supply_en, sys_rst_n;
   int bad_count, samples_checked, cycles;
   // Small counts keep the run short; checks below follow from them.
   gdfm_top #(.LEGS(3), .OC_CYC(8), .RUNDEB_CYC(20), .RSTDEB_CYC(4)) i_dut (
      .CLOCK(clock), .RST_N(rst_n), .EXTERNAL_RESET_PIN_N(ext_n),
      .ENABLE(enable), .RUN(run), .PWM_HIGH(pwm_h), .PWM_LOW(pwm_l),
      .TRIP_HIGH(trip_h), .TRIP_LOW(trip_l),
      .GATE_SUPPLY_RAIL_UV(gate_uv), .LOGIC_SUPPLY_UV(logic_uv),
      .TEMP_WARN(temp_warn), .TEMP_OFF(temp_off), .OVERCURRENT(ovc),
      .HIGH_SIDE_GATE(gate_h), .LOW_SIDE_GATE(gate_l),
      .FAULT_FLAG_LOW(fl_lo), .FAULT_FLAG_HIGH(fl_hi),
      .SENSE_ENABLE(sense_en), .SUPPLY_ENABLE(supply_en),
      .SYSTEM_RESET_N(sys_rst_n));
   gdfm_mcu_model i_mcu (.clock(clock), .rst_n(rst_n), .run_req(run_req),
      .auto_drop(auto_drop), .pwm_h_req(pwm_h_req), .pwm_l_req(pwm_l_req),
      .flag_low(fl_lo), .flag_high(fl_hi), .run(run), .pwm_high(pwm_h),
      .pwm_low(pwm_l));
   // 25 ns clock.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // A hang counts as a mismatch and ends the run.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         bad_count++;
         final_report;
      end
   end
   // Compares one result; case inequality keeps unknowns from passing.
   task automatic cmp(input string nm, input logic [7:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Waits n rising edges, then settles to the falling edge for checks.
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic flags(input logic [1:0] e);
      cmp("flags", {6'h0, e}, {6'h0, fl_hi, fl_lo});
   endtask
   task automatic gates(input logic [2:0] h, l);
      cmp("gates", {2'h0, h, l}, {2'h0, gate_h, gate_l});
   endtask
   // Standby: gates held low, logic supply code only.
   task automatic s_standby;
      @(posedge clock);
      enable <= 1'b1;
      pwm_h_req <= 3'h1;
      wt(4);
      gates(3'h0, 3'h0);
      flags(2'h0);
      cmp("sense", 8'h00, {7'h0, sense_en});
      @(posedge clock);
      logic_uv <= 1'b1;
      gate_uv <= 1'b1;
      wt(3);
      flags(2'h3);
      @(posedge clock);
      logic_uv <= 1'b0;
      gate_uv <= 1'b0;
      wt(3);
      flags(2'h0);
   endtask
   // Run with the interlock on leg 1.
   task automatic s_run;
      @(posedge clock);
      run_req <= 1'b1;
      pwm_l_req <= 3'h6;
      wt(6);
      gates(3'h1, 3'h6);
      cmp("sense", 8'h01, {7'h0, sense_en});
      @(posedge clock);
      pwm_h_req <= 3'h3;
      wt(4);
      gates(3'h1, 3'h4);
      @(posedge clock);
      pwm_h_req <= 3'h1;
      wt(4);
   endtask
   // Gate supply loss, temperature warning and their precedence.
   task automatic s_supply;
      @(posedge clock);
      gate_uv <= 1'b1;
      temp_warn <= 1'b1;
      wt(4);
      flags(2'h1);
      gates(3'h0, 3'h0);
      @(posedge clock);
      gate_uv <= 1'b0;
      wt(5);
      flags(2'h2);
      gates(3'h1, 3'h6);
      @(posedge clock);
      temp_warn <= 1'b0;
      wt(3);
      flags(2'h0);
   endtask
   // Short overcurrent pulse is filtered; a long one latches.
   task automatic s_overcurrent;
      int k;
      @(posedge clock);
      ovc <= 1'b1;
      wt(5);
      @(posedge clock);
      ovc <= 1'b0;
      auto_drop <= 1'b1;
      wt(3);
      flags(2'h0);
      @(posedge clock);
      ovc <= 1'b1;
      for (k = 0; k < 20 && {fl_hi, fl_lo} !== 2'h3; k++) wt(0);
      flags(2'h3);
      gates(3'h0, 3'h0);
      @(posedge clock);
      ovc <= 1'b0;
      wt(3);
      cmp("run", 8'h00, {7'h0, run});
      flags(2'h0);
      gates(3'h0, 3'h0);
      @(posedge clock);
      run_req <= 1'b0;
      auto_drop <= 1'b0;
      wt(2);
      @(posedge clock);
      run_req <= 1'b1;
      wt(6);
      gates(3'h1, 3'h6);
   endtask
   // Leg 2 high side shorts right at turn-on.
   task automatic s_short;
      int k;
      @(posedge clock);
      pwm_h_req <= 3'h5;
      pwm_l_req <= 3'h2;
      trip_h <= 3'h4;
      trip_l <= 3'h1;
      wt(150);
      flags(2'h0);
      gates(3'h5, 3'h2);
      for (k = 0; k < 150 && {fl_hi, fl_lo} !== 2'h3; k++) wt(0);
      flags(2'h3);
      wt(0);
      gates(3'h1, 3'h2);
      @(posedge clock);
      trip_h <= 3'h0;
      wt(10);
      flags(2'h3);
      gates(3'h1, 3'h2);
      @(posedge clock);
      run_req <= 1'b0;
      wt(3);
      flags(2'h0);
      @(posedge clock);
      run_req <= 1'b1;
      wt(6);
      gates(3'h5, 3'h2);
   endtask
   // Long run-low returns to standby.
   task automatic s_leave;
      @(posedge clock);
      run_req <= 1'b0;
      wt(30);
      gates(3'h0, 3'h0);
      cmp("sense", 8'h00, {7'h0, sense_en});
   endtask
   // Reset pin spike ignored, long low honoured; then thermal switch-off.
   task automatic s_reset_pin;
      @(posedge clock);
      ext_n <= 1'b0;
      wt(1);
      cmp("sysrst", 8'h01, {7'h0, sys_rst_n});
      @(posedge clock);
      ext_n <= 1'b1;
      wt(3);
      cmp("sysrst", 8'h01, {7'h0, sys_rst_n});
      @(posedge clock);
      ext_n <= 1'b0;
      wt(10);
      cmp("sysrst", 8'h00, {7'h0, sys_rst_n});
      @(posedge clock);
      ext_n <= 1'b1;
      wt(3);
      cmp("sysrst", 8'h01, {7'h0, sys_rst_n});
      cmp("supply", 8'h01, {7'h0, supply_en});
      @(posedge clock);
      temp_off <= 1'b1;
      wt(3);
      cmp("supply", 8'h00, {7'h0, supply_en});
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic final_report;
      $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      {rst_n, enable, gate_uv, logic_uv, temp_warn, temp_off} = 6'h0;
      {ovc, run_req, auto_drop} = 3'h0;
      {pwm_h_req, pwm_l_req, trip_h, trip_l} = 12'h000;
      ext_n = 1'b1;
      bad_count = 0;
      samples_checked = 0;
      cycles = 0;
      wt(5);
      flags(2'h3);
      @(posedge clock);
      rst_n <= 1'b1;
      s_standby;
      s_run;
      s_supply;
      s_overcurrent;
      s_short;
      s_leave;
      s_reset_pin;
      final_report;
   end
endmodule
